// ==== pirq_pkg.sv ====
package pirq_pkg;

  // register offsets (byte addresses; all are 32-bit word aligned except the control offset 0x0B)
  localparam logic [7:0] PIRQ_FLAGS_OFS   = 8'h0C;
  localparam logic [7:0] PIRQ_ENABLES_OFS = 8'h8C;
  localparam logic [7:0] PIRQ_CTRL_OFS    = 8'h0B;
  localparam logic [7:0] PIRQ_IRQ_STAT_OFS = 8'h10;
  localparam logic [7:0] PIRQ_IRQ_MASK_OFS = 8'h14;

  // flag bit positions
  localparam int PIRQ_BIT_PSP   = 7;
  localparam int PIRQ_BIT_ADC   = 6;
  localparam int PIRQ_BIT_RX    = 5;
  localparam int PIRQ_BIT_TX    = 4;
  localparam int PIRQ_BIT_SSP   = 3;
  localparam int PIRQ_BIT_CCP   = 2;
  localparam int PIRQ_BIT_TMRB  = 1;
  localparam int PIRQ_BIT_TMRA  = 0;
  // control register bits
  localparam int PIRQ_BIT_GATE  = 6;
  localparam int PIRQ_BIT_GLOB  = 7;

  // reset values
  localparam logic [7:0] PIRQ_FLAGS_RST = 8'h00;
  localparam logic [7:0] PIRQ_EN_RST    = 8'h00;
  localparam logic [7:0] PIRQ_CTRL_RST  = 8'h00;

  // software-writable flag bits (the two buffer flags are read-only)
  localparam logic [7:0] PIRQ_SW_MASK   = 8'hCF;

  // capture/compare unit modes
  typedef enum logic [1:0]
  {
    PIRQ_CCP_OFF     = 2'h0,
    PIRQ_CCP_CAPTURE = 2'h1,
    PIRQ_CCP_COMPARE = 2'h2,
    PIRQ_CCP_PWM     = 2'h3
  } pirq_ccp_mode_t;

  // peripheral condition pulses and levels
  typedef struct packed
  {
    logic psp_done;
    logic adc_done;
    logic rx_full;
    logic tx_empty;
    logic ssp_done;
    logic ccp_capture;
    logic ccp_match;
    logic tmrb_match;
    logic tmra_ovf;
  } pirq_events_t;

  // register-bus request
  typedef struct packed
  {
    logic       cyc;
    logic       stb;
    logic       we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } pirq_wb_req_t;

  // bus answer phase
  typedef enum logic [1:0]
  {
    PIRQ_BUS_IDLE = 2'b01,
    PIRQ_BUS_ACK  = 2'b10
  } pirq_bus_state_t;

  function automatic logic [7:0] pirq_w1c(input logic [7:0] cur, input logic [7:0] clr,
                                          input logic [7:0] set);
    pirq_w1c = (cur & ~clr) | set;
  endfunction

endpackage

// ==== pirq_flag_bits.sv ====
`timescale 1ns/1ps
`default_nettype none
module pirq_flag_bits
  import pirq_pkg::*;
#(
  parameter bit HAS_PSP = 1'b1
)
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // peripheral side
  input  wire pirq_events_t ev_i,
  input  wire pirq_ccp_mode_t ccp_mode_i,
  // software side
  input  wire logic        wr_i,
  input  wire logic [7:0]  wdat_i,
  // state
  output logic [7:0]       flags_o,
  output logic [7:0]       set_o
);

  typedef struct packed
  {
    logic [7:0] flags;
  } pirq_fb_state_t;

  pirq_fb_state_t st;
  pirq_fb_state_t next_st;
  logic [7:0]     set_v;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    set_v = 8'h00;
    set_v[PIRQ_BIT_PSP]  = ev_i.psp_done & HAS_PSP;
    set_v[PIRQ_BIT_ADC]  = ev_i.adc_done;
    set_v[PIRQ_BIT_SSP]  = ev_i.ssp_done;
    set_v[PIRQ_BIT_CCP]  = (ccp_mode_i == PIRQ_CCP_CAPTURE && ev_i.ccp_capture)
                        | (ccp_mode_i == PIRQ_CCP_COMPARE && ev_i.ccp_match);
    set_v[PIRQ_BIT_TMRB] = ev_i.tmrb_match;
    set_v[PIRQ_BIT_TMRA] = ev_i.tmra_ovf;
    next_st = st;
    // software writes only zeros that stick; a same-cycle event wins
    if (wr_i)
    begin
      next_st.flags = (st.flags & (wdat_i | ~PIRQ_SW_MASK)) | set_v;
    end
    else
    begin
      next_st.flags = st.flags | set_v;
    end
    // buffer flags mirror buffer state and cannot be written
    next_st.flags[PIRQ_BIT_RX] = ev_i.rx_full;
    next_st.flags[PIRQ_BIT_TX] = ev_i.tx_empty;
    if (!HAS_PSP)
    begin
      next_st.flags[PIRQ_BIT_PSP] = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st.flags <= PIRQ_FLAGS_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign flags_o = st.flags;
  assign set_o   = set_v;

  AST_SET_WINS: assert property (@(posedge clk_i) disable iff (rst_i)
    (ev_i.adc_done) |=> flags_o[PIRQ_BIT_ADC])
    else $error("adc flag not set after event");
  AST_CCP_PWM: assert property (@(posedge clk_i) disable iff (rst_i)
    (ccp_mode_i == PIRQ_CCP_PWM && !$past(flags_o[PIRQ_BIT_CCP]) && !flags_o[PIRQ_BIT_CCP])
      |=> !flags_o[PIRQ_BIT_CCP] || $past(ccp_mode_i) != PIRQ_CCP_PWM)
    else $error("ccp flag set in pwm mode");
  AST_TMRA_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    (flags_o[PIRQ_BIT_TMRA] && !(wr_i && !wdat_i[PIRQ_BIT_TMRA])) |=> flags_o[PIRQ_BIT_TMRA])
    else $error("timer a flag dropped without write");
  AST_TMRB_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_i && !wdat_i[PIRQ_BIT_TMRB] && !ev_i.tmrb_match) |=> !flags_o[PIRQ_BIT_TMRB])
    else $error("timer b flag not cleared");

endmodule
`default_nettype wire

// ==== pirq_irq_status.sv ====
`timescale 1ns/1ps
`default_nettype none
module pirq_irq_status
  import pirq_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // events and software
  input  wire logic [7:0] ev_i,
  input  wire logic       clr_wr_i,
  input  wire logic [7:0] clr_i,
  input  wire logic       mask_wr_i,
  input  wire logic [7:0] mask_i,
  // state
  output logic [7:0]      status_o,
  output logic [7:0]      mask_o,
  output logic            irq_o
);

  typedef struct packed
  {
    logic [7:0] status;
    logic [7:0] mask;
  } pirq_is_state_t;

  pirq_is_state_t st;
  pirq_is_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_st = st;
    next_st.status = pirq_w1c(st.status, clr_wr_i ? clr_i : 8'h00, ev_i);
    if (mask_wr_i)
    begin
      next_st.mask = mask_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign status_o = st.status;
  assign mask_o   = st.mask;
  assign irq_o    = |(st.status & st.mask);

  AST_STAT_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
    (|ev_i) |=> ((status_o & $past(ev_i)) == $past(ev_i)))
    else $error("status event lost");

endmodule
`default_nettype wire

// ==== pirq_top.sv ====
// Behaviour
// - flags set regardless of any enable
// - no parallel port: bit reserved, zero
// - converter flag bit 6, sticky
// - rx flag bit 5 follows buffer full
// - tx flag bit 4 follows buffer empty
// - sync serial flag bit 3 sticky
// - capture mode sets bit 2, sticky
// - compare match sets bit 2, sticky
// - timer b match sets bit 1
// - timer a overflow sets bit 0
// - all zero at reset; mixed access
// - enable register, same bit positions
// - peripheral gate bit 6 required; only periph_req_o uses it, irq_o is not gated by it
`timescale 1ns/1ps
`default_nettype none
module pirq_top
  import pirq_pkg::*;
#(
  parameter bit HAS_PSP = 1'b1
)
(
  // clock and reset
  input  wire logic           clk_i,
  input  wire logic           rst_i,
  // wishbone slave
  input  wire logic           cyc_i,
  input  wire logic           stb_i,
  input  wire logic           we_i,
  input  wire logic [3:0]     sel_i,
  input  wire logic [7:0]     adr_i,
  input  wire logic [31:0]    dat_i,
  output logic [31:0]         dat_o,
  output logic                ack_o,
  // peripheral conditions
  input  wire logic           psp_done_i,
  input  wire logic           adc_done_i,
  input  wire logic           rx_full_i,
  input  wire logic           tx_empty_i,
  input  wire logic           ssp_done_i,
  input  wire logic           ccp_capture_i,
  input  wire logic           ccp_match_i,
  input  wire pirq_ccp_mode_t ccp_mode_i,
  input  wire logic           tmrb_match_i,
  input  wire logic           tmra_ovf_i,
  // interrupts
  output logic                periph_req_o,
  output logic                irq_o
);

  typedef struct packed
  {
    pirq_bus_state_t bus;
    logic [31:0]     rdat;
    logic [7:0]      enables;
    logic [7:0]      ctrl;
  } pirq_top_state_t;

  pirq_top_state_t st;
  pirq_top_state_t next_st;
  pirq_events_t    ev;
  logic [7:0]      flags;
  logic [7:0]      set_ev;
  logic [7:0]      irq_status;
  logic [7:0]      irq_mask;
  logic            take;
  logic            wr_b0;
  logic            wr_flags;
  logic            wr_stat;
  logic            wr_mask;
  logic            req;

  ////////////////////////////////////////////////////////////////////////////
  // events arrive from same-clock peripheral logic, no synchroniser
  always_comb
  begin
    ev.psp_done    = psp_done_i;
    ev.adc_done    = adc_done_i;
    ev.rx_full     = rx_full_i;
    ev.tx_empty    = tx_empty_i;
    ev.ssp_done    = ssp_done_i;
    ev.ccp_capture = ccp_capture_i;
    ev.ccp_match   = ccp_match_i;
    ev.tmrb_match  = tmrb_match_i;
    ev.tmra_ovf    = tmra_ovf_i;
  end

  // write takes effect on the request edge; ack follows one cycle later
  assign take     = cyc_i && stb_i && (st.bus == PIRQ_BUS_IDLE);
  assign wr_b0    = take && we_i && sel_i[0];
  assign wr_flags = wr_b0 && (adr_i == PIRQ_FLAGS_OFS);
  assign wr_stat  = wr_b0 && (adr_i == PIRQ_IRQ_STAT_OFS);
  assign wr_mask  = wr_b0 && (adr_i == PIRQ_IRQ_MASK_OFS);

  pirq_flag_bits #(
    .HAS_PSP (HAS_PSP)
  ) u_flags (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ev_i       (ev),
    .ccp_mode_i (ccp_mode_i),
    .wr_i       (wr_flags),
    .wdat_i     (dat_i[7:0]),
    .flags_o    (flags),
    .set_o      (set_ev)
  );

  ////////////////////////////////////////////////////////////////////////////
  // request: any enabled flag, gated by the two control bits
  assign req = |(flags & st.enables)
             && st.ctrl[PIRQ_BIT_GATE]
             && st.ctrl[PIRQ_BIT_GLOB];
  assign periph_req_o = req;

  // sticky record of flag-set events for software polling
  pirq_irq_status u_irq (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ev_i      (set_ev),
    .clr_wr_i  (wr_stat),
    .clr_i     (dat_i[7:0]),
    .mask_wr_i (wr_mask),
    .mask_i    (dat_i[7:0]),
    .status_o  (irq_status),
    .mask_o    (irq_mask),
    .irq_o     (irq_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_st = st;
    case (st.bus)
      PIRQ_BUS_IDLE:
      begin
        if (take)
        begin
          next_st.bus  = PIRQ_BUS_ACK;
          next_st.rdat = 32'h0000_0000;
          case (adr_i)
            PIRQ_FLAGS_OFS:    next_st.rdat[7:0] = flags;
            PIRQ_ENABLES_OFS:  next_st.rdat[7:0] = st.enables;
            PIRQ_CTRL_OFS:     next_st.rdat[7:0] = st.ctrl;
            PIRQ_IRQ_STAT_OFS: next_st.rdat[7:0] = irq_status;
            PIRQ_IRQ_MASK_OFS: next_st.rdat[7:0] = irq_mask;
            default:           next_st.rdat      = 32'h0000_0000;
          endcase
          if (wr_b0 && adr_i == PIRQ_ENABLES_OFS)
          begin
            // enabling should follow a flag clear; stale flags fire at once
            next_st.enables = HAS_PSP ? dat_i[7:0] : (dat_i[7:0] & 8'h7F);
          end
          if (wr_b0 && adr_i == PIRQ_CTRL_OFS)
          begin
            next_st.ctrl = dat_i[7:0] & 8'hC0;
          end
        end
      end
      PIRQ_BUS_ACK:
      begin
        next_st.bus = PIRQ_BUS_IDLE;
      end
      default:
      begin
        next_st.bus = PIRQ_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st.bus     <= PIRQ_BUS_IDLE;
      st.rdat    <= 32'h0000_0000;
      st.enables <= PIRQ_EN_RST;
      st.ctrl    <= PIRQ_CTRL_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign ack_o = (st.bus == PIRQ_BUS_ACK);
  assign dat_o = st.rdat;

  ////////////////////////////////////////////////////////////////////////////
  AST_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
    !st.ctrl[PIRQ_BIT_GATE] |-> !periph_req_o)
    else $error("request without peripheral gate");
  AST_REQ: assert property (@(posedge clk_i) disable iff (rst_i)
    (|(flags & st.enables) && st.ctrl[PIRQ_BIT_GATE] && st.ctrl[PIRQ_BIT_GLOB]) |-> periph_req_o)
    else $error("request missing");
  AST_FLAG_NO_EN: assert property (@(posedge clk_i) disable iff (rst_i)
    (tmra_ovf_i && st.enables == 8'h00) |=> flags[PIRQ_BIT_TMRA])
    else $error("flag waits for enable");
  AST_RX: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i |=> flags[PIRQ_BIT_RX] == $past(rx_full_i))
    else $error("rx flag wrong");
  AST_TX_RO: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_flags && !tx_empty_i) |=> !flags[PIRQ_BIT_TX])
    else $error("tx flag writable");
  AST_NO_PSP: assert property (@(posedge clk_i) disable iff (rst_i)
    !HAS_PSP |-> !flags[PIRQ_BIT_PSP])
    else $error("reserved bit set");
  AST_SSP: assert property (@(posedge clk_i) disable iff (rst_i)
    ssp_done_i |=> flags[PIRQ_BIT_SSP] [*2] or ##1 (ack_o))
    else $error("ssp flag not held");
  AST_CAPT: assert property (@(posedge clk_i) disable iff (rst_i)
    (ccp_mode_i == PIRQ_CCP_CAPTURE && ccp_capture_i) |=> flags[PIRQ_BIT_CCP])
    else $error("capture flag missing");
  AST_CMP: assert property (@(posedge clk_i) disable iff (rst_i)
    (ccp_mode_i == PIRQ_CCP_COMPARE && ccp_match_i) |=> flags[PIRQ_BIT_CCP])
    else $error("compare flag missing");
  AST_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)
    else $error("ack timing wrong");
  AST_RESET: assert property (@(posedge clk_i)
    $past(rst_i) |-> (flags == 8'h00))
    else $error("flags not zero after reset");
  AST_ADC: assert property (@(posedge clk_i) disable iff (rst_i)
    adc_done_i |=> flags[PIRQ_BIT_ADC])
    else $error("converter flag missing");

  ////////////////////////////////////////////////////////////////////////////
  // bus answer: one pulse per request, upper bytes idle
  AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack longer than one cycle");

  AST_ACK_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
    (!(cyc_i && stb_i) && !ack_o) |=> !ack_o)
    else $error("ack without request");

  AST_RDAT_HI: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |-> (dat_o[31:8] == 24'h00_0000))
    else $error("read data upper bytes not zero");

  // enable and control registers
  AST_EN_KEEP: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr_b0 && adr_i == PIRQ_ENABLES_OFS) |=> st.enables == $past(st.enables))
    else $error("enables changed without write");

  AST_EN_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_b0 && adr_i == PIRQ_ENABLES_OFS) |=> st.enables[6:0] == $past(dat_i[6:0]))
    else $error("enables write lost");

  AST_EN_PSP: assert property (@(posedge clk_i) disable iff (rst_i)
    !HAS_PSP |-> !st.enables[PIRQ_BIT_PSP])
    else $error("reserved enable bit set");

  AST_CTRL_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_b0 && adr_i == PIRQ_CTRL_OFS) |=> (st.ctrl[PIRQ_BIT_GATE] == $past(dat_i[PIRQ_BIT_GATE])
      && st.ctrl[5:0] == 6'h00))
    else $error("control write wrong");

  // request gating; a stale flag fires as soon as its enable is set
  AST_GLOB: assert property (@(posedge clk_i) disable iff (rst_i)
    !st.ctrl[PIRQ_BIT_GLOB] |-> !periph_req_o)
    else $error("request without global enable");

  AST_NO_EN: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.enables == 8'h00) |-> !periph_req_o)
    else $error("request with all enables off");

  // flag setting and holding
  AST_PSP_SET: assert property (@(posedge clk_i) disable iff (rst_i)
    (HAS_PSP && psp_done_i) |=> flags[PIRQ_BIT_PSP])
    else $error("parallel port flag missing");

  AST_TMRB_SET: assert property (@(posedge clk_i) disable iff (rst_i)
    tmrb_match_i |=> flags[PIRQ_BIT_TMRB])
    else $error("timer b flag missing");

  AST_TMRA_SET: assert property (@(posedge clk_i) disable iff (rst_i)
    tmra_ovf_i |=> flags[PIRQ_BIT_TMRA])
    else $error("timer a flag missing");

  AST_TX: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i |=> flags[PIRQ_BIT_TX] == $past(tx_empty_i))
    else $error("tx flag wrong");

  AST_RX_RO: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_flags && rx_full_i) |=> flags[PIRQ_BIT_RX])
    else $error("rx flag writable");

  AST_ADC_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_flags && !dat_i[PIRQ_BIT_ADC] && !adc_done_i) |=> !flags[PIRQ_BIT_ADC])
    else $error("converter flag not cleared");

  AST_SSP_QUIET: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ssp_done_i && !flags[PIRQ_BIT_SSP]) |=> !flags[PIRQ_BIT_SSP])
    else $error("ssp flag set without event");

  AST_CCP_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    (flags[PIRQ_BIT_CCP] && !wr_flags) |=> flags[PIRQ_BIT_CCP])
    else $error("unit flag dropped without write");

  AST_CCP_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    (ccp_mode_i == PIRQ_CCP_OFF && !flags[PIRQ_BIT_CCP]) |=> !flags[PIRQ_BIT_CCP])
    else $error("unit flag set while off");

  AST_CAPT_NO_MATCH: assert property (@(posedge clk_i) disable iff (rst_i)
    (ccp_mode_i == PIRQ_CCP_CAPTURE && !ccp_capture_i && !flags[PIRQ_BIT_CCP]) |=> !flags[PIRQ_BIT_CCP])
    else $error("match set flag in capture mode");

  AST_PWM_QUIET: assert property (@(posedge clk_i) disable iff (rst_i)
    (ccp_mode_i == PIRQ_CCP_PWM && !flags[PIRQ_BIT_CCP]) |=> !flags[PIRQ_BIT_CCP])
    else $error("unit flag set in pwm mode");

endmodule
`default_nettype wire

// ==== pirq_periph_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pirq_periph_model
  import pirq_pkg::*;
(
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // bench commands
  input  wire logic [8:0]   cmd_i,
  input  wire logic         rx_i,
  input  wire logic         tx_i,
  // peripheral conditions
  output var pirq_events_t  ev_o
);
  ////////////////////////////////////////////////////////////////////////////////
  // pulses last one cycle; buffer levels track the bench, one cycle late
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ev_o          <= '0;
      ev_o.tx_empty <= 1'b1;
    end
    else
    begin
      ev_o          <= pirq_events_t'(cmd_i);
      ev_o.rx_full  <= rx_i;
      ev_o.tx_empty <= tx_i;
    end
  end
endmodule
`default_nettype wire

// ==== pirq_top_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module pirq_top_tb_top;
  import pirq_pkg::*;
  logic           clk_i = 1'b0;
  logic           rst_i = 1'b1;
  logic           cyc = 1'b0;
  logic           stb = 1'b0;
  logic           we = 1'b0;
  logic [3:0]     sel = 4'h0;
  logic [7:0]     adr = 8'h00;
  logic [31:0]    dat = 32'h0;
  logic [31:0]    dat_o;
  logic           ack_o;
  logic [8:0]     pls = 9'h000;
  logic           rx_lvl = 1'b0;
  logic           tx_lvl = 1'b1;
  pirq_ccp_mode_t ccp_mode = PIRQ_CCP_OFF;
  pirq_events_t   ev;
  logic           periph_req;
  logic           irq;
  logic [31:0]    dat_np;
  logic [7:0]     last_np = 8'h00;
  int             err_count = 0;
  int             checks_done = 0;

  always #5 clk_i = ~clk_i;

  pirq_periph_model MODEL (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(pls), .rx_i(rx_lvl), .tx_i(tx_lvl), .ev_o(ev));

  pirq_top DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .sel_i(sel),
    .adr_i(adr), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .psp_done_i(ev.psp_done),
    .adc_done_i(ev.adc_done), .rx_full_i(ev.rx_full), .tx_empty_i(ev.tx_empty),
    .ssp_done_i(ev.ssp_done), .ccp_capture_i(ev.ccp_capture), .ccp_match_i(ev.ccp_match),
    .ccp_mode_i(ccp_mode), .tmrb_match_i(ev.tmrb_match), .tmra_ovf_i(ev.tmra_ovf),
    .periph_req_o(periph_req), .irq_o(irq));

  // variant without the parallel port, sharing every input
  pirq_top #(.HAS_PSP(1'b0)) DUT_NOPSP (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .sel_i(sel), .adr_i(adr), .dat_i(dat), .dat_o(dat_np), .ack_o(), .psp_done_i(ev.psp_done),
    .adc_done_i(ev.adc_done), .rx_full_i(ev.rx_full), .tx_empty_i(ev.tx_empty),
    .ssp_done_i(ev.ssp_done), .ccp_capture_i(ev.ccp_capture), .ccp_match_i(ev.ccp_match),
    .ccp_mode_i(ccp_mode), .tmrb_match_i(ev.tmrb_match), .tmra_ovf_i(ev.tmra_ovf),
    .periph_req_o(), .irq_o());

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (err_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ack is sampled as it stood at the edge; only the watchdog ends a wait
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    sel <= 4'hF;
    adr <= a;
    dat <= {24'h0, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1)
    begin
      @(posedge clk_i);
    end
    r = dat_o[7:0];
    last_np = dat_np[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
    chk1(ack_o, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] r;
    wb(1'b0, a, 8'h00, r);
    chk8(r, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    wb(1'b1, a, d, r);
  endtask

  // order: psp adc rx tx ssp cap match tmrb tmra
  task automatic fire(input logic [8:0] e);
    @(posedge clk_i);
    pls <= e;
    @(posedge clk_i);
    pls <= 9'h000;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(PIRQ_FLAGS_OFS, 8'h10);
    rd(PIRQ_ENABLES_OFS, 8'h00);
    rd(PIRQ_CTRL_OFS, 8'h00);
    rd(8'h40, 8'h00);
    chk1(periph_req, 1'b0);
  endtask

  // enables all off, so any set proves independence from them
  task automatic t_sticky;
    ccp_mode <= PIRQ_CCP_CAPTURE;
    fire(9'h100);
    rd(PIRQ_FLAGS_OFS, 8'h90);
    chk8(last_np, 8'h10);
    fire(9'h080);
    rd(PIRQ_FLAGS_OFS, 8'hD0);
    fire(9'h010);
    rd(PIRQ_FLAGS_OFS, 8'hD8);
    fire(9'h008);
    rd(PIRQ_FLAGS_OFS, 8'hDC);
    fire(9'h002);
    rd(PIRQ_FLAGS_OFS, 8'hDE);
    fire(9'h001);
    rd(PIRQ_FLAGS_OFS, 8'hDF);
    chk1(periph_req, 1'b0);
    wr(PIRQ_FLAGS_OFS, 8'hFE);
    rd(PIRQ_FLAGS_OFS, 8'hDE);
    wr(PIRQ_FLAGS_OFS, 8'h00);
    rd(PIRQ_FLAGS_OFS, 8'h10);
    wr(PIRQ_FLAGS_OFS, 8'hFF);
    rd(PIRQ_FLAGS_OFS, 8'h10);
  endtask

  task automatic t_buffers;
    rx_lvl <= 1'b1;
    tx_lvl <= 1'b0;
    repeat (2) @(posedge clk_i);
    rd(PIRQ_FLAGS_OFS, 8'h20);
    wr(PIRQ_FLAGS_OFS, 8'h00);
    rd(PIRQ_FLAGS_OFS, 8'h20);
    rx_lvl <= 1'b0;
    tx_lvl <= 1'b1;
    repeat (2) @(posedge clk_i);
    rd(PIRQ_FLAGS_OFS, 8'h10);
  endtask

  task automatic t_ccp;
    for (int m = 0; m < 4; m++)
    begin
      ccp_mode <= pirq_ccp_mode_t'(m);
      fire(9'h008);
      rd(PIRQ_FLAGS_OFS, (m == 1) ? 8'h14 : 8'h10);
      wr(PIRQ_FLAGS_OFS, 8'h00);
      fire(9'h004);
      rd(PIRQ_FLAGS_OFS, (m == 2) ? 8'h14 : 8'h10);
      wr(PIRQ_FLAGS_OFS, 8'h00);
    end
  endtask

  task automatic t_req;
    wr(PIRQ_FLAGS_OFS, 8'h00);
    wr(PIRQ_ENABLES_OFS, 8'h40);
    rd(PIRQ_ENABLES_OFS, 8'h40);
    fire(9'h080);
    rd(PIRQ_FLAGS_OFS, 8'h50);
    chk1(periph_req, 1'b0);
    wr(PIRQ_CTRL_OFS, 8'h40);
    chk1(periph_req, 1'b0);
    wr(PIRQ_CTRL_OFS, 8'h80);
    chk1(periph_req, 1'b0);
    wr(PIRQ_CTRL_OFS, 8'hC0);
    chk1(periph_req, 1'b1);
    wr(PIRQ_ENABLES_OFS, 8'h01);
    chk1(periph_req, 1'b0);
    fire(9'h001);
    rd(PIRQ_FLAGS_OFS, 8'h51);
    chk1(periph_req, 1'b1);
    wr(PIRQ_FLAGS_OFS, 8'h00);
    chk1(periph_req, 1'b0);
    wr(PIRQ_CTRL_OFS, 8'h00);
  endtask

  task automatic t_irq;
    wr(PIRQ_IRQ_STAT_OFS, 8'hFF);
    rd(PIRQ_IRQ_STAT_OFS, 8'h00);
    wr(PIRQ_IRQ_MASK_OFS, 8'h01);
    rd(PIRQ_IRQ_MASK_OFS, 8'h01);
    chk1(irq, 1'b0);
    fire(9'h001);
    rd(PIRQ_IRQ_STAT_OFS, 8'h01);
    chk1(irq, 1'b1);
    wr(PIRQ_IRQ_MASK_OFS, 8'h00);
    chk1(irq, 1'b0);
    wr(PIRQ_IRQ_MASK_OFS, 8'h01);
    chk1(irq, 1'b1);
    wr(PIRQ_IRQ_STAT_OFS, 8'h01);
    chk1(irq, 1'b0);
    rd(PIRQ_IRQ_STAT_OFS, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_sticky();
    t_buffers();
    t_ccp();
    t_req();
    t_irq();
    give_verdict();
  end

  // run needs a few hundred cycles; this leaves ample margin
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
